//--- dic_pkg.sv
`default_nettype none
package dic_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_HZ = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_HZ;
  // Scan cycle in milliseconds
  localparam int unsigned SCAN_MS = 5;
  // Fixed AC deactivation delay in milliseconds
  localparam int unsigned AC_DELAY_MS = 30;
  // Delay setting limit in milliseconds (1800.000 s)
  localparam int unsigned DELAY_MAX_MS = 1_800_000;
  localparam int DELAY_W = 21;
  // Reset values of settings
  localparam logic POL_RESET = 1'b0;   // 0 = normally open
  localparam logic AC_RESET = 1'b0;    // Disabled
  localparam logic [20:0] DELAY_RESET = 21'h000000;
endpackage : dic_pkg
`default_nettype wire

//--- dic_conditioner.sv
`timescale 1ns/10ps
`default_nettype none
module dic_conditioner #(
  parameter int N = 8,
  parameter int MS_DIV = dic_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] input_channel_n,
  input wire logic [N-1:0] polarity_nc,
  input wire logic [N-1:0] ac_mode,
  input wire logic [N*dic_pkg::DELAY_W-1:0] act_delay_ms,
  input wire logic [N*dic_pkg::DELAY_W-1:0] drop_delay_ms,
  output logic [N-1:0] state_out,
  output logic [N-1:0] logic_out,
  output logic [N-1:0] relay_output_channel_n,
  output logic scan_tick
);
  import dic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Delay words above the 1800 s ceiling are held at the ceiling, so a stray
  // large setting stretches a timer no further, except that AC mode adds its 30 ms after the clamp
  function automatic logic [DELAY_W-1:0] clamp_ms(input logic [DELAY_W-1:0] v);
    logic [DELAY_W-1:0] lim;
    lim = DELAY_W'(DELAY_MAX_MS);
    return (v > lim) ? lim : v;
  endfunction : clamp_ms

  ////////////////////////////////////////////////////////////////////////////
  // Time base: 1 ms enable and 5 ms scan enable
  // One shared divider for all channels keeps every input on the same scan,
  // at the cost of a 0 to 5 ms phase error against the field contact
  logic [31:0] div_q;
  logic [2:0] scan_cnt_q;
  logic ms_en;
  logic scan_en;
  assign ms_en = (div_q == 32'(MS_DIV - 1));
  assign scan_en = ms_en && (scan_cnt_q == 3'(SCAN_MS - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 32'h00000000;
      scan_cnt_q <= 3'h0;
    end else begin
      div_q <= ms_en ? 32'h00000000 : div_q + 32'h00000001;
      if (ms_en) begin
        scan_cnt_q <= scan_en ? 3'h0 : scan_cnt_q + 3'h1;
      end
    end
  end

  // Pins cross into the clock domain through two flops
  logic [N-1:0] sync1_q;
  logic [N-1:0] sync2_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= input_channel_n;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel conditioning; thresholds are analog and fixed, none here
  // only delays and polarity
  localparam logic [DELAY_W-1:0] AC_MS = DELAY_W'(AC_DELAY_MS);
  localparam logic [DELAY_W-1:0] SCAN_W = DELAY_W'(SCAN_MS);
  logic [N-1:0] samp_q;
  logic [N-1:0] rep_q;
  logic [N-1:0] logic_q;
  logic [N-1:0] relay_q;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic [DELAY_W-1:0] tmr_q;
      logic [DELAY_W-1:0] act_d;
      logic [DELAY_W-1:0] drop_d;
      logic [DELAY_W-1:0] need;
      logic want;
      assign act_d = clamp_ms(act_delay_ms[g*DELAY_W +: DELAY_W]);
      assign drop_d = clamp_ms(drop_delay_ms[g*DELAY_W +: DELAY_W]) + (ac_mode[g] ? AC_MS : '0);
      assign want = samp_q[g] ^ polarity_nc[g];
      assign need = rep_q[g] ? drop_d : act_d;

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          samp_q[g] <= 1'b0;
        end else if (scan_en) begin
          samp_q[g] <= sync2_q[g];
        end
      end

      // Delays resolve in whole scans: a setting of d ms releases after
      // ceil((d+1)/5) scans, so settings between scan steps round up
      // delay timers, timer runs in scan steps of 5 ms
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          tmr_q <= DELAY_RESET;
          rep_q[g] <= 1'b0;
        end else if (scan_en) begin
          if (want == rep_q[g]) begin
            tmr_q <= DELAY_RESET;
          end else if (tmr_q + SCAN_W > need) begin
            rep_q[g] <= want;
            tmr_q <= DELAY_RESET;
          end else begin
            tmr_q <= tmr_q + SCAN_W;
          end
        end
      end

      // Per-channel timer checks: no early change, no late change
      a_act_wait: assert property (@(posedge clk) disable iff (rst)
        scan_en && !rep_q[g] && want && (tmr_q + SCAN_W <= act_d) |=> !rep_q[g])
        else $error("activation before its delay");
      a_act_fire: assert property (@(posedge clk) disable iff (rst)
        scan_en && !rep_q[g] && want && (tmr_q + SCAN_W > act_d) |=> rep_q[g])
        else $error("activation late after its delay");
      a_drop_wait: assert property (@(posedge clk) disable iff (rst)
        scan_en && rep_q[g] && !want && (tmr_q + SCAN_W <= drop_d) |=> rep_q[g])
        else $error("drop-off before its delay");
      a_drop_fire: assert property (@(posedge clk) disable iff (rst)
        scan_en && rep_q[g] && !want && (tmr_q + SCAN_W > drop_d) |=> !rep_q[g])
        else $error("drop-off late after its delay");
      // AC mode holds the input through 30 ms whatever the drop setting
      a_ac_hold: assert property (@(posedge clk) disable iff (rst)
        scan_en && ac_mode[g] && rep_q[g] && !want && (tmr_q + SCAN_W <= AC_MS) |=> rep_q[g])
        else $error("AC mode released inside 30 ms");
      a_timer_clear: assert property (@(posedge clk) disable iff (rst)
        scan_en && (want == rep_q[g]) |=> tmr_q == DELAY_RESET)
        else $error("timer not cancelled on return");
    end
  endgenerate

  // consumer and relay stages, one scan each
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      logic_q <= '0;
      relay_q <= '0;
    end else if (scan_en) begin
      logic_q <= rep_q;
      relay_q <= logic_q;
    end
  end

  // Scan pulse out registered
  logic tick_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= scan_en;
    end
  end

  assign state_out = rep_q;
  assign logic_out = logic_q;
  assign relay_output_channel_n = relay_q;
  assign scan_tick = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_relay_follows: assert property (@(posedge clk) disable iff (rst)
    scan_en |=> relay_q == $past(logic_q))
    else $error("relay stage did not follow consumer stage");
  a_logic_follows: assert property (@(posedge clk) disable iff (rst)
    scan_en |=> logic_q == $past(rep_q))
    else $error("consumer stage did not follow reported state");
  a_state_scan: assert property (@(posedge clk) disable iff (rst)
    !scan_en |=> $stable(rep_q))
    else $error("reported state changed off scan");
  a_sample_scan: assert property (@(posedge clk) disable iff (rst)
    !scan_en |=> $stable(samp_q))
    else $error("sample changed off scan");
  a_no_change_eq: assert property (@(posedge clk) disable iff (rst)
    scan_en && ((samp_q ^ polarity_nc) == rep_q) |=> rep_q == $past(rep_q))
    else $error("state changed without raw change");
  a_zero_delay: assert property (@(posedge clk) disable iff (rst)
    scan_en && act_delay_ms == '0 && drop_delay_ms == '0 && ac_mode == '0
    |=> rep_q == $past(samp_q ^ polarity_nc))
    else $error("zero delay did not pass in one scan");
  a_tick_out: assert property (@(posedge clk) disable iff (rst)
    scan_en |=> scan_tick ##1 !scan_tick)
    else $error("scan tick pulse wrong");
  a_polarity_dir: assert property (@(posedge clk) disable iff (rst)
    $rose(rep_q[0]) |-> $past(samp_q[0] ^ polarity_nc[0]))
    else $error("rise against polarity");

  // Later stages move only on the scan, so consumers see one clean step
  a_logic_hold: assert property (@(posedge clk) disable iff (rst)
    !scan_en |=> $stable(logic_q))
    else $error("consumer stage changed off scan");
  a_relay_hold: assert property (@(posedge clk) disable iff (rst)
    !scan_en |=> $stable(relay_q))
    else $error("relay stage changed off scan");

  // Divider counters stay inside their cycle
  a_div_range: assert property (@(posedge clk) disable iff (rst)
    div_q <= 32'(MS_DIV - 1))
    else $error("millisecond divider out of range");
  a_scan_range: assert property (@(posedge clk) disable iff (rst)
    scan_cnt_q <= 3'(SCAN_MS - 1))
    else $error("scan counter out of range");

  // Sample takes the synchronised pin, and the tick marks only scans
  a_samp_source: assert property (@(posedge clk) disable iff (rst)
    scan_en |=> samp_q == $past(sync2_q))
    else $error("sample not taken from synchroniser");
  a_tick_only: assert property (@(posedge clk) disable iff (rst)
    scan_tick |-> $past(scan_en))
    else $error("scan tick without scan");
endmodule : dic_conditioner
`default_nettype wire

//--- dic_field.sv
`timescale 1ns/10ps
`default_nettype none
module dic_field (
  input wire logic clk,
  output logic [1:0] input_channel_n
);
  initial input_channel_n = 2'h0;
  // Contact moves after a falling edge
  task automatic put(input logic v);
    @(negedge clk);
    input_channel_n[0] = v;
  endtask : put
  // Either contact moves after a falling edge
  task automatic put_ch(input int ch, input logic v);
    @(negedge clk);
    input_channel_n[ch] = v;
  endtask : put_ch
endmodule : dic_field
`default_nettype wire

//--- test_digital_input_conditioner.sv
`timescale 1ns/10ps
`default_nettype none
module test_digital_input_conditioner;
  import dic_pkg::*;
  logic clk, rst, tick;
  logic [1:0] raw, pol, ac, st, lo, rl;
  logic [2*DELAY_W-1:0] act, drp;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  // Short millisecond so that one scan is ten clocks
  localparam int MSD = 2;
  dic_field field (.clk(clk), .input_channel_n(raw));
  dic_conditioner #(.N(2), .MS_DIV(MSD)) dut (.clk(clk), .rst(rst), .input_channel_n(raw),
    .polarity_nc(pol), .ac_mode(ac), .act_delay_ms(act), .drop_delay_ms(drp),
    .state_out(st), .logic_out(lo), .relay_output_channel_n(rl), .scan_tick(tick));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Hang guard, far above the ~90 scans used
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // Wait n scans, then settle to the falling edge
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff tick === 1'b1);
    @(negedge clk);
  endtask : ticks
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %b exp %b", $time, got, exp);
    end
  endtask : chk
  // Pipeline view of channel 0: state, consumer, relay
  task automatic step(input int n, input logic [2:0] exp);
    ticks(n);
    chk({st[0], lo[0], rl[0]}, exp);
  endtask : step
  // Same view of channel 1
  task automatic step1(input int n, input logic [2:0] exp);
    ticks(n);
    chk({st[1], lo[1], rl[1]}, exp);
  endtask : step1
  ////////////////////////////////////////////////////////////////
  task automatic t_zero();
    field.put(1);
    step(1, 3'h0);
    step(1, 3'h4);
    step(1, 3'h6);
    step(1, 3'h7);
    field.put(0);
    step(4, 3'h0);
    $display("t_zero done");
  endtask : t_zero
  // Short pulse must not leak and must restart the timer
  task automatic t_act();
    act[20:0] = 21'h000014;
    field.put(1);
    ticks(2);
    field.put(0);
    step(8, 3'h0);
    field.put(1);
    step(5, 3'h0);
    step(1, 3'h4);
    field.put(0);
    step(4, 3'h0);
    act = '0;
    $display("t_act done");
  endtask : t_act
  // Drop-off of 10 ms, then AC mode alone (30 ms)
  task automatic t_drop(input int i);
    ac[0] = i[0];
    drp[20:0] = (i == 0) ? 21'h00000A : 21'h000000;
    field.put(1);
    step(4, 3'h7);
    field.put(0);
    step((i == 0) ? 3 : 7, 3'h7);
    step(1, 3'h3);
    step(3, 3'h0);
    $display("t_drop %0d done", i);
  endtask : t_drop
  // Channel 0 turned normally closed, energized, released, then back to open
  task automatic t_pol();
    ac = {2{AC_RESET}};
    pol[0] = 1'b1;
    step(1, 3'h4);
    field.put(1);
    step(1, 3'h6);
    step(1, 3'h3);
    step(2, 3'h0);
    field.put(0);
    step(4, 3'h7);
    pol[0] = POL_RESET;
    step(3, 3'h0);
    $display("t_pol done");
  endtask : t_pol
  // Channel 1, normally closed: 7 ms drop-off plus AC mode, 10 ms activation
  task automatic t_chan1();
    ac[1] = 1'b1;
    drp[DELAY_W +: DELAY_W] = 21'h000007;
    act[DELAY_W +: DELAY_W] = 21'h00000A;
    field.put_ch(1, 1'b1);
    step1(8, 3'h7);
    step1(1, 3'h3);
    step1(2, 3'h0);
    field.put_ch(1, 1'b0);
    step1(3, 3'h0);
    step1(1, 3'h4);
    step1(2, 3'h7);
    ac[1] = AC_RESET;
    act = '0;
    drp = '0;
    $display("t_chan1 done");
  endtask : t_chan1
  // Scan pulses stand one clock and come every five milliseconds
  task automatic t_tick();
    int n;
    n = 0;
    @(negedge clk iff tick === 1'b1);
    @(negedge clk);
    n = 1;
    while (tick !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    check_count++;
    if (n != SCAN_MS * MSD) begin
      error_cnt++;
      $display("MISMATCH t=%0t scan period %0d", $time, n);
    end
    $display("t_tick done");
  endtask : t_tick
  // Reset in mid-run clears every stage; the closed channel comes back
  task automatic t_reset();
    rst = 1;
    @(negedge clk);
    chk({st[1], lo[1], rl[1]}, 3'h0);
    chk({tick, st[0], rl[0]}, 3'h0);
    rst = 0;
    step1(1, 3'h4);
    step1(2, 3'h7);
    $display("t_reset done");
  endtask : t_reset
  initial begin
    rst = 1;
    pol = 2'h2;
    ac = {2{AC_RESET}};
    act = '0;
    drp = '0;
    repeat (2) @(negedge clk);
    chk({st[0], lo[0], rl[0]}, 3'h0);
    rst = 0;
    ticks(2);
    chk({2'h0, st[1]}, 3'h1);
    t_zero();
    t_act();
    t_drop(0);
    t_drop(1);
    t_pol();
    t_chan1();
    t_tick();
    t_reset();
    end_of_test();
  end
endmodule : test_digital_input_conditioner
`default_nettype wire
